// ==== verilog/pwr_seq_defines.svh ====
`ifndef PWR_SEQ_DEFINES_SVH
`define PWR_SEQ_DEFINES_SVH
// Purpose: constants of the power button and wake sequencer
// Assumes: 250 MHz standby clock
// Notes: long counts are overridable parameters of the top module
`define CLK_MHZ 250
`define HOLD_TIME_MS 4000
`define HOLD_CYCLES (`HOLD_TIME_MS * 1000 * `CLK_MHZ)
`define DEBOUNCE_TIME_MS 20
`define DEBOUNCE_CYCLES (`DEBOUNCE_TIME_MS * 1000 * `CLK_MHZ)
`define CNT_W 32
`define SLP_S1 2'h0
`define SLP_S3 2'h1
`define SLP_S4 2'h2
`define SLP_S5 2'h3
`endif

// ==== verilog/pwr_seq_pkg.sv ====
// Purpose: types of the power button and wake sequencer
// Assumes: included defines
// Notes: none
package pwr_seq_pkg;
  typedef enum logic [4:0] {
    ST_S0 = 5'h01,
    ST_S1 = 5'h02,
    ST_S3 = 5'h04,
    ST_S4 = 5'h08,
    ST_S5 = 5'h10
  } pstate_t;

  typedef struct packed {
    logic pwr_btn;
    logic rtc_alarm;
    logic pcie_wake;
    logic modem_ring;
    logic ps2_act;
    logic usb_act;
    logic lan_wake;
    logic pme;
  } wake_src_t;

  typedef struct packed {
    logic main_rails_on;
    logic devices_on;
    logic cpu_run;
    logic cold_boot;
  } pwr_ctl_t;
endpackage : pwr_seq_pkg

// ==== verilog/pwr_seq.sv ====
// Purpose: power switch timing, sleep state sequencing and wake gating
// Assumes: one always-on standby clock; all wake and switch pins asynchronous
// Notes: os requests are one-cycle pulses from logic on the same clock
//
// Operation
// - Short press: off to on, on to sleep, sleep to on
// - Long press while working forces soft-off
// - Long press while sleeping goes to soft-off
// - Only OS requests, switch or wake events change states
// - OS can command soft-off
// - S3, S4, S5 power only wake logic
// - Leaving S5 is a cold boot
// - Switch, RTC, PCIe wake from S1-S5
// - Ring, PS/2, USB wake S1/S3 only
// - LAN, PME in S5 need option, default off
// - LAN wake in S5 starts system when enabled
// - Closed cover switch flags intrusion
// - PME wake needs wake-on-PME option
// - Soft-off drops main rails, keeps standby
`include "pwr_seq_defines.svh"
module pwr_seq #(
  parameter logic [`CNT_W-1:0] HOLD_CYCLES = `CNT_W'(`HOLD_CYCLES),
  parameter logic [`CNT_W-1:0] DEBOUNCE_CYCLES = `CNT_W'(`DEBOUNCE_CYCLES)
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic pwr_btn_n_i,
  input wire pwr_seq_pkg::wake_src_t wake_i,
  input wire logic cover_sw_closed_i,
  input wire logic os_req_i,
  input wire logic [1:0] os_req_state_i,
  input wire logic os_req_off_i,
  input wire logic os_req_wake_i,
  input wire logic s5_wake_en_i,
  input wire logic pme_wake_en_i,
  input wire logic intrusion_clr_i,
  output logic [4:0] state_o,
  output pwr_seq_pkg::pwr_ctl_t pwr_o,
  output logic intrusion_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: every switch, cover and wake pin level passes two stages before any logic
  logic btn_raw;
  logic cover_closed;
  logic [7:0] wk_raw;
  pwr_seq_sync #(.W(1)) u_sync_btn (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .d_i(~pwr_btn_n_i),
    .q_o(btn_raw)
  );
  pwr_seq_sync #(.W(1)) u_sync_cover (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .d_i(cover_sw_closed_i),
    .q_o(cover_closed)
  );
  pwr_seq_sync #(.W(8)) u_sync_wake (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .d_i(wake_i),
    .q_o(wk_raw)
  );
  wire pwr_seq_pkg::wake_src_t wk = pwr_seq_pkg::wake_src_t'(wk_raw);

  ////////////////////////////////////////////////////////////////////////////
  // Debounce: level must hold for the whole window before it is believed
  logic [`CNT_W-1:0] db_cnt_q;
  logic btn_q;
  wire logic db_diff = btn_raw != btn_q;
  wire logic db_done = db_cnt_q >= DEBOUNCE_CYCLES - `CNT_W'(1);
  // Any return to the believed level restarts the window
  wire logic db_clr = !db_diff || db_done;
  pwr_seq_timer #(.W(`CNT_W)) u_db_timer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .clr_i(db_clr),
    .inc_i(db_diff),
    .cnt_o(db_cnt_q)
  );
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      btn_q <= 1'b0;
    end else if (ce_i && db_diff && db_done) begin
      btn_q <= btn_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Press timer: a long press acts at the threshold, a short one on release
  logic [`CNT_W-1:0] hold_cnt_q;
  logic long_done_q;
  logic btn_d1_q;
  wire logic press_edge = btn_q && !btn_d1_q;
  wire logic release_edge = !btn_q && btn_d1_q;
  wire logic long_hit = btn_q && !long_done_q && (hold_cnt_q >= HOLD_CYCLES - `CNT_W'(1));
  wire logic short_press = release_edge && !long_done_q;
  // Count stops at the threshold so a very long hold cannot wrap
  wire logic hold_inc = btn_q && !long_hit && !long_done_q;
  pwr_seq_timer #(.W(`CNT_W)) u_hold_timer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .clr_i(press_edge),
    .inc_i(hold_inc),
    .cnt_o(hold_cnt_q)
  );
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      long_done_q <= 1'b0;
      btn_d1_q <= 1'b0;
    end else if (ce_i) begin
      btn_d1_q <= btn_q;
      if (press_edge) begin
        long_done_q <= 1'b0;
      end else if (long_hit) begin
        long_done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake gating per sleep state
  logic [4:0] st_q;
  wire logic in_s1 = st_q == pwr_seq_pkg::ST_S1;
  wire logic in_s3 = st_q == pwr_seq_pkg::ST_S3;
  wire logic in_s4 = st_q == pwr_seq_pkg::ST_S4;
  wire logic in_s5 = st_q == pwr_seq_pkg::ST_S5;
  wire logic sleeping = in_s1 | in_s3 | in_s4;
  wire logic wake_any = wk.rtc_alarm | wk.pcie_wake;
  wire logic wake_light = (in_s1 | in_s3) & (wk.modem_ring | wk.ps2_act | wk.usb_act);
  wire logic lan_ok = (sleeping & wk.lan_wake) | (in_s5 & s5_wake_en_i & wk.lan_wake);
  wire logic pme_ok = pme_wake_en_i & wk.pme & (sleeping | (in_s5 & s5_wake_en_i));
  wire logic wake_ev = (sleeping | in_s5) & (wake_any | wake_light | lan_ok | pme_ok);

  ////////////////////////////////////////////////////////////////////////////
  // State machine
  pwr_seq_pkg::pstate_t st_d;
  logic cold_d;
  logic cold_q;
  wire pwr_seq_pkg::pstate_t req_st =
    (os_req_state_i == `SLP_S1) ? pwr_seq_pkg::ST_S1 :
    (os_req_state_i == `SLP_S3) ? pwr_seq_pkg::ST_S3 :
    (os_req_state_i == `SLP_S4) ? pwr_seq_pkg::ST_S4 : pwr_seq_pkg::ST_S5;
  always_comb begin
    st_d = pwr_seq_pkg::pstate_t'(st_q);
    cold_d = cold_q;
    case (pwr_seq_pkg::pstate_t'(st_q))
      pwr_seq_pkg::ST_S0: begin
        if (long_hit) begin
          st_d = pwr_seq_pkg::ST_S5;
        end else if (os_req_off_i) begin
          st_d = pwr_seq_pkg::ST_S5;
        end else if (os_req_i) begin
          st_d = req_st;
        end else if (short_press) begin
          st_d = pwr_seq_pkg::ST_S1;
        end
      end
      pwr_seq_pkg::ST_S1, pwr_seq_pkg::ST_S3, pwr_seq_pkg::ST_S4: begin
        if (long_hit) begin
          st_d = pwr_seq_pkg::ST_S5;
        end else if (short_press || wake_ev || os_req_wake_i) begin
          st_d = pwr_seq_pkg::ST_S0;
        end
      end
      pwr_seq_pkg::ST_S5: begin
        if (short_press || wake_ev || os_req_wake_i) begin
          st_d = pwr_seq_pkg::ST_S0;
          cold_d = 1'b1;
        end
      end
      default: st_d = pwr_seq_pkg::ST_S5;
    endcase
    // Cold boot marker lasts only for the working state it opened
    if (st_d != pwr_seq_pkg::ST_S0) begin
      cold_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= pwr_seq_pkg::ST_S5;
      cold_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      cold_q <= cold_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  logic [4:0] state_q;
  pwr_seq_pkg::pwr_ctl_t pwr_q;
  logic intr_q;
  pwr_seq_flag u_intr_flag (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .set_i(cover_closed),
    .clr_i(intrusion_clr_i),
    .flag_o(intr_q)
  );
  wire logic d_s0 = st_d == pwr_seq_pkg::ST_S0;
  wire logic d_s1 = st_d == pwr_seq_pkg::ST_S1;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= 5'h10;
      pwr_q <= '0;
    end else if (ce_i) begin
      state_q <= st_d;
      pwr_q.main_rails_on <= d_s0 | d_s1;
      pwr_q.devices_on <= d_s0 | d_s1;
      pwr_q.cpu_run <= d_s0;
      pwr_q.cold_boot <= cold_d;
    end
  end
  assign state_o = state_q;
  assign pwr_o = pwr_q;
  assign intrusion_o = intr_q;
endmodule : pwr_seq

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for asynchronous pin levels
module pwr_seq_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // Only the second stage is read; the first may be metastable
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule : pwr_seq_sync

////////////////////////////////////////////////////////////////////////////////
// Up counter with clear, used for debounce and press timing
module pwr_seq_timer #(
  parameter int W = 32
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic inc_i,
  output logic [W-1:0] cnt_o
);
  logic [W-1:0] cnt_q;
  // Clear wins so a new press always starts timing from zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (clr_i) begin
        cnt_q <= '0;
      end else if (inc_i) begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end
  assign cnt_o = cnt_q;
endmodule : pwr_seq_timer

////////////////////////////////////////////////////////////////////////////////
// Sticky flag set by hardware and cleared by software
module pwr_seq_flag (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_q;
  // Set beats clear so a cover opened during the clear is kept
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_q <= 1'b0;
    end else if (ce_i) begin
      flag_q <= set_i | (flag_q & ~clr_i);
    end
  end
  assign flag_o = flag_q;
endmodule : pwr_seq_flag

// ==== dv/pwr_seq_props.sv ====
// Purpose: port checks of pwr_seq; Assumes: one clock; Notes: bound below
module pwr_seq_props (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic pwr_btn_n_i,
  input wire pwr_seq_pkg::wake_src_t wake_i,
  input wire logic cover_sw_closed_i,
  input wire logic os_req_i,
  input wire logic [1:0] os_req_state_i,
  input wire logic os_req_off_i,
  input wire logic os_req_wake_i,
  input wire logic s5_wake_en_i,
  input wire logic intrusion_clr_i,
  input wire logic [4:0] state_o,
  input wire pwr_seq_pkg::pwr_ctl_t pwr_o,
  input wire logic intrusion_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Switch kept up long enough that no release is still in the debounce
  sequence s_btn_up;
    pwr_btn_n_i [*8];
  endsequence
  sequence s_calm;
    pwr_btn_n_i && !os_req_wake_i && !s5_wake_en_i && wake_i[6:5] == 2'h0;
  endsequence
  property p_off;
    s_btn_up ##0 (state_o == 5'h01 && os_req_off_i) |=> state_o == 5'h10;
  endproperty
  a_off: assert property (p_off) else $error("soft-off not taken");
  property p_req;
    s_btn_up ##0 (state_o == 5'h01 && os_req_i && !os_req_off_i)
      |=> state_o == (5'h02 << $past(os_req_state_i));
  endproperty
  a_req: assert property (p_req) else $error("sleep request wrong");
  property p_rails;
    pwr_o.main_rails_on == (state_o[0] | state_o[1]) && pwr_o.devices_on == pwr_o.main_rails_on;
  endproperty
  a_rails: assert property (p_rails) else $error("rails wrong");
  property p_cpu;
    pwr_o.cpu_run == state_o[0];
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu run wrong");
  property p_rtc;
    $rose(wake_i.rtc_alarm) && !state_o[0] && pwr_btn_n_i |-> ##[1:4] state_o == 5'h01;
  endproperty
  a_rtc: assert property (p_rtc) else $error("alarm wake missed");
  property p_cold;
    $rose(state_o[0]) |-> pwr_o.cold_boot == $past(state_o[4]);
  endproperty
  a_cold: assert property (p_cold) else $error("cold boot wrong");
  property p_intr;
    cover_sw_closed_i |-> ##[1:4] intrusion_o;
  endproperty
  a_intr: assert property (p_intr) else $error("intrusion missed");
  property p_hold;
    !intrusion_clr_i [*3] ##0 intrusion_o |=> intrusion_o;
  endproperty
  a_hold: assert property (p_hold) else $error("intrusion dropped");
  property p_s5;
    s_calm [*8] ##1 s_calm [*4] ##0 state_o == 5'h10 |=> state_o == 5'h10;
  endproperty
  a_s5: assert property (p_s5) else $error("masked wake from S5");
endmodule : pwr_seq_props
bind pwr_seq pwr_seq_props props (.clk_i, .arst_n_i, .pwr_btn_n_i, .wake_i,
  .cover_sw_closed_i, .os_req_i, .os_req_state_i, .os_req_off_i, .os_req_wake_i,
  .s5_wake_en_i, .intrusion_clr_i, .state_o, .pwr_o, .intrusion_o);

// ==== dv/pwr_far.sv ====
// Purpose: switch and wake pins; Assumes: bench commands; Notes: switch chatters
module pwr_far (
  input wire logic clk_i,
  input wire logic press_i,
  input wire pwr_seq_pkg::wake_src_t req_i,
  output logic pwr_btn_n_o,
  output pwr_seq_pkg::wake_src_t wake_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] age_q;
  initial begin
    pwr_btn_n_o = 1'b1;
    wake_o = '0;
    age_q = 2'h0;
  end
  // Contacts bounce once after closing, so the debounce is really exercised
  always @(posedge clk_i) begin
    age_q <= press_i ? ((age_q == 2'h3) ? age_q : age_q + 2'h1) : 2'h0;
    pwr_btn_n_o <= ~press_i | (age_q == 2'h1);
    wake_o <= {press_i, req_i[6:0]};
  end
endmodule : pwr_far

// ==== dv/pwr_seq_tb.sv ====
// Purpose: random and corner tests of pwr_seq; Assumes: short counts; Notes: ce_i tied high
module pwr_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, arst_n = 1'b0, press = 1'b0, cov = 1'b0, clr = 1'b0, btn_n, intr;
  logic oq = 1'b0, of = 1'b0, ow = 1'b0, s5e = 1'b0, pme = 1'b0;
  logic [1:0] ost = 2'h0;
  logic [4:0] st;
  pwr_seq_pkg::wake_src_t wq = '0, wp;
  pwr_seq_pkg::pwr_ctl_t pw;
  int miscompares = 0, compares = 0;
  int lens[6] = '{14, 14, 14, 60, 0, 60};
  logic [4:0] exps[6] = '{5'h01, 5'h02, 5'h01, 5'h10, 5'h04, 5'h10};
  always #2 clk_i = ~clk_i;
  pwr_far far (.clk_i(clk_i), .press_i(press), .req_i(wq), .pwr_btn_n_o(btn_n), .wake_o(wp));
  pwr_seq #(.HOLD_CYCLES(32'h28), .DEBOUNCE_CYCLES(32'h4)) dut (.clk_i(clk_i),
    .arst_n_i(arst_n), .ce_i(1'b1), .pwr_btn_n_i(btn_n), .wake_i(wp), .cover_sw_closed_i(cov),
    .os_req_i(oq), .os_req_state_i(ost), .os_req_off_i(of), .os_req_wake_i(ow),
    .s5_wake_en_i(s5e), .pme_wake_en_i(pme), .intrusion_clr_i(clr), .state_o(st),
    .pwr_o(pw), .intrusion_o(intr));
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic go(input int i);
    ow = 1'b1;
    cyc(1);
    ow = 1'b0;
    ost = 2'(i);
    cyc(2);
    if (i == 3 && $urandom % 2) of = 1'b1;
    else oq = 1'b1;
    cyc(1);
    oq = 1'b0;
    of = 1'b0;
    cyc(2);
  endtask : go
  function automatic logic [4:0] ew(input logic [4:0] s, input int b);
    logic ok;
    ok = b >= 5 || (b >= 2 && b <= 4 && s <= 5'h04) || (b <= 1 && (s != 5'h10 || s5e));
    if (b == 0 && !pme) ok = 1'b0;
    return ok ? 5'h01 : s;
  endfunction : ew
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    logic [4:0] e;
    void'($urandom(32'hC4FC));
    cyc(3);
    arst_n = 1'b1;
    chk(st, 5'h10);
    chk({1'b0, pw}, 5'h00);
    cyc(16);
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 7; b++) begin
        s5e = $urandom % 2;
        pme = $urandom % 2;
        go(i);
        of = 1'b1;
        cyc(1);
        of = 1'b0;
        cyc(1);
        chk(st, 5'(5'h02 << i));
        e = ew(st, b);
        wq[b] = 1'b1;
        cyc(6);
        chk(st, e);
        chk({2'h0, pw[3:1]}, {2'h0, e[0] | e[1], e[0] | e[1], e[0]});
        chk({4'h0, pw.cold_boot}, {4'h0, e[0] && i == 3});
        wq = '0;
        cyc(4);
      end
    end
    go(3);
    for (int k = 0; k < 6; k++) begin
      if (lens[k] == 0) go(1);
      else begin
        press = 1'b1;
        cyc(lens[k]);
        press = 1'b0;
        cyc(20);
      end
      chk(st, exps[k]);
    end
    cov = 1'b1;
    cyc(1);
    cov = 1'b0;
    cyc(24);
    chk({4'h0, intr}, 5'h01);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(4);
    chk({4'h0, intr}, 5'h00);
    complete_run();
  end
  // Whole run is near 830 cycles, so this only trips on a hang
  initial begin
    #40000;
    miscompares++;
    complete_run();
  end
endmodule : pwr_seq_tb
